// File: pkg/crsi_cfg.svh
`ifndef CRSI_CFG_SVH
`define CRSI_CFG_SVH

// ==========================================================
// Register file layout
`define CRSI_NREG 32
`define CRSI_RF_TOP 16'h0020
`define CRSI_PAIR_X 4'hd
`define CRSI_PAIR_Y 4'he
`define CRSI_PAIR_Z 4'hf

// ==========================================================
// Stack pointer
`define CRSI_SRAM_END 16'h009f
`define CRSI_SP_STEP1 16'h0001
`define CRSI_SP_STEP2 16'h0002

// ==========================================================
// Status flags and sequencing
`define CRSI_GIE_BIT 7
`define CRSI_SEQ_LAST 3'h3
`define CRSI_CNT_STEP 3'h1

`endif

// File: pkg/crsi_pkg.sv
// ==========================================================
// Shared types
package crsi_pkg;

    // Interrupt sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_wake,
        st_entry,
        st_return
    } crsi_state_e;

    // Pointer addressing modes
    typedef enum logic [1:0] {
        pm_plain,
        pm_disp,
        pm_postinc,
        pm_predec
    } crsi_ptr_mode_e;

endpackage : crsi_pkg

// File: src/crsi_regfile.sv
`timescale 1ns/100ps
`default_nettype none
`include "crsi_cfg.svh"

// ==========================================================
// Working register file, three byte and two pair read ports
module crsi_regfile (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [4:0] rd_a_idx,
    input wire logic [4:0] rd_b_idx,
    input wire logic [4:0] rd_c_idx,
    input wire logic [3:0] rd_w_idx,
    input wire logic [3:0] rd_p_idx,
    output logic [7:0] rd_a,
    output logic [7:0] rd_b,
    output logic [7:0] rd_c,
    output logic [15:0] rd_w,
    output logic [15:0] rd_p,
    input wire logic we,
    input wire logic we_wide,
    input wire logic [4:0] wr_idx,
    input wire logic [15:0] wr_data
);
    typedef struct packed {
        logic [`CRSI_NREG-1:0][7:0] r;
    } crsi_rf_s;

    crsi_rf_s st;
    crsi_rf_s next_st;

    // Pair: even register low byte, odd register high byte
    function automatic logic [15:0] pair_rd(input crsi_rf_s s, input logic [3:0] p);
        return {s.r[{p, 1'h1}], s.r[{p, 1'h0}]};
    endfunction : pair_rd

    // Byte write or aligned pair write
    always_comb begin
        next_st = st;
        if (we && we_wide) begin
            next_st.r[{wr_idx[4:1], 1'h0}] = wr_data[7:0];
            next_st.r[{wr_idx[4:1], 1'h1}] = wr_data[15:8];
        end else if (we) begin
            next_st.r[wr_idx] = wr_data[7:0];
        end
    end

    // Read ports
    assign rd_a = st.r[rd_a_idx];
    assign rd_b = st.r[rd_b_idx];
    assign rd_c = st.r[rd_c_idx];
    assign rd_w = pair_rd(st, rd_w_idx);
    assign rd_p = pair_rd(st, rd_p_idx);

    // Storage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : crsi_regfile
`default_nettype wire

// File: src/crsi_stack_ptr.sv
`timescale 1ns/100ps
`default_nettype none
`include "crsi_cfg.svh"

// ==========================================================
// Down-growing stack pointer, high byte only if wide enough
module crsi_stack_ptr #(
    parameter int SP_W = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic dec1,
    input wire logic dec2,
    input wire logic inc1,
    input wire logic inc2,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    output logic [15:0] sp
);
    localparam logic [15:0] RST_SP = `CRSI_SRAM_END;
    localparam bit HAS_HI = (SP_W > 8);

    if (SP_W < 8 || SP_W > 16) begin : g_chk
        $error("crsi_stack_ptr: SP_W must be 8 to 16");
    end

    typedef struct packed {
        logic [SP_W-1:0] sp;
    } crsi_sp_s;

    crsi_sp_s st;
    crsi_sp_s next_st;
    logic [15:0] full;

    // Software writes win over implicit steps
    always_comb begin
        next_st = st;
        full = 16'(st.sp);
        if (wr_lo || (wr_hi && HAS_HI)) begin
            if (wr_lo) full[7:0] = wdata;
            if (wr_hi && HAS_HI) full[15:8] = wdata;
            next_st.sp = full[SP_W-1:0];
        end else if (dec2) begin
            next_st.sp = st.sp - SP_W'(`CRSI_SP_STEP2);
        end else if (dec1) begin
            next_st.sp = st.sp - SP_W'(`CRSI_SP_STEP1);
        end else if (inc2) begin
            next_st.sp = st.sp + SP_W'(`CRSI_SP_STEP2);
        end else if (inc1) begin
            next_st.sp = st.sp + SP_W'(`CRSI_SP_STEP1);
        end
    end

    // Absent high byte reads as zero
    assign sp = 16'(st.sp);

    // Power-on value is the last SRAM address
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st.sp <= RST_SP[SP_W-1:0];
        end else begin
            st <= next_st;
        end
    end

endmodule : crsi_stack_ptr
`default_nettype wire

// File: src/crsi_core_ctrl.sv
// Functional notes
// - Thirty-two byte registers, four operand/result schemes
// - Registers mapped at lowest 32 data addresses
// - Top six registers form three pointers
// - Pointers support displacement, post-increment, pre-decrement
// - Stack grows downward; pointer marks top
// - Reset loads stack pointer with SRAM end
// - Push drops pointer by one, call/entry two
// - Pop raises pointer by one, returns two
// - Stack pointer is two bytes; high optional
// - Core runs on undivided chip clock
// - Fetch overlaps execute; read-op-write each cycle
// - Lower vector means higher priority
// - Take needs individual and global enable
// - Entry clears global enable; return sets it
// - Hardware or write-one clears pending flag
// - Disabled flags stay pending, served by priority
// - Level sources request only while present
// - One instruction runs after return first
// - Status flags not saved by hardware
// - Global disable acts in same cycle
// - Instruction after global enable runs first
// - Entry four cycles, plus four from sleep
// - Return four cycles, pops PC, sets enable
// - Global enable is status bit seven
`timescale 1ns/100ps
`default_nettype none
`include "crsi_cfg.svh"

module crsi_core_ctrl #(
    parameter int N_IRQ = 9,
    parameter logic [N_IRQ-1:0] LEVEL_MASK = '0,
    parameter int PC_W = 9,
    parameter int SP_W = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [4:0] op_a_idx,
    input wire logic [4:0] op_b_idx,
    input wire logic [3:0] op_w_idx,
    output logic [7:0] op_a,
    output logic [7:0] op_b,
    output logic [15:0] op_w,
    input wire logic res_we,
    input wire logic res_wide,
    input wire logic [4:0] res_idx,
    input wire logic [15:0] res_data,
    input wire logic ds_rd,
    input wire logic ds_wr,
    input wire logic [15:0] ds_addr,
    input wire logic [7:0] ds_wdata,
    output logic ds_reg_hit,
    output logic [7:0] ds_rdata,
    input wire logic ptr_go,
    input wire logic [1:0] ptr_sel,
    input wire crsi_pkg::crsi_ptr_mode_e ptr_mode,
    input wire logic [5:0] ptr_disp,
    output logic [15:0] ptr_addr,
    input wire logic push1,
    input wire logic pop1,
    input wire logic sub_call,
    input wire logic sub_exit,
    input wire logic sp_wr_lo,
    input wire logic sp_wr_hi,
    input wire logic [7:0] sp_wdata,
    output logic [7:0] stack_ptr_low,
    output logic [7:0] stack_ptr_high,
    input wire logic [6:0] alu_flags,
    input wire logic status_wr,
    input wire logic [7:0] status_wdata,
    output logic [7:0] status_flags_reg,
    input wire logic instr_done,
    input wire logic global_irq_on,
    input wire logic global_irq_off,
    input wire logic return_from_irq,
    input wire logic sleeping,
    input wire logic [PC_W-1:0] pc_now,
    input wire logic [N_IRQ-1:0] irq_event,
    input wire logic [N_IRQ-1:0] irq_level,
    input wire logic [N_IRQ-1:0] irq_en,
    input wire logic [N_IRQ-1:0] flag_clr,
    output logic [N_IRQ-1:0] irq_flags,
    output logic irq_take,
    output logic [$clog2(N_IRQ+1)-1:0] irq_vector,
    output logic core_busy,
    output logic stk_we,
    output logic stk_rd,
    output logic [15:0] stk_addr,
    output logic [7:0] stk_wdata,
    input wire logic [7:0] stk_rdata,
    output logic pc_load,
    output logic [PC_W-1:0] pc_restore
);
    localparam int VW = $clog2(N_IRQ + 1);

    if (N_IRQ < 1 || N_IRQ > 30 || PC_W < 1 || PC_W > 16) begin : g_chk
        $error("crsi_core_ctrl: N_IRQ or PC_W out of range");
    end

    // ==========================================================
    // State
    typedef struct packed {
        crsi_pkg::crsi_state_e st;
        logic [2:0] cnt;
        logic gie;
        logic [6:0] sflags;
        logic [N_IRQ-1:0] flags;
        logic take;
        logic [VW-1:0] vec;
        logic busy;
        logic [15:0] pc_save;
        logic [7:0] pc_hi;
        logic [PC_W-1:0] pc_restore;
        logic pc_load;
        logic stk_we;
        logic stk_rd;
        logic [15:0] stk_addr;
        logic [7:0] stk_wdata;
        logic [7:0] op_a;
        logic [7:0] op_b;
        logic [15:0] op_w;
        logic ds_hit;
        logic [7:0] ds_rdata;
        logic [15:0] ptr_addr;
    } crsi_core_s;

    crsi_core_s st;
    crsi_core_s next_st;

    logic [7:0] rf_a;
    logic [7:0] rf_b;
    logic [7:0] rf_c;
    logic [15:0] rf_w;
    logic [15:0] ptr_base;
    logic [3:0] ptr_pair;
    logic [15:0] ptr_eff;
    logic [15:0] ptr_new;
    logic ptr_upd;
    logic ds_reg_wr;
    logic rf_we;
    logic rf_wide;
    logic [4:0] rf_idx;
    logic [15:0] rf_data;
    logic [15:0] sp16;
    logic sp_dec1;
    logic sp_dec2;
    logic sp_inc1;
    logic sp_inc2;
    logic [N_IRQ-1:0] req;
    logic [N_IRQ-1:0] hw_clr;
    logic can_take;

    // Lowest pending index wins; vector 0 stays with reset
    function automatic logic [VW-1:0] pick_vec(input logic [N_IRQ-1:0] r);
        logic [VW-1:0] v;
        v = '0;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (r[i]) v = VW'(i + 1);
        end
        return v;
    endfunction : pick_vec

    // Pointer select to register pair
    function automatic logic [3:0] sel_pair(input logic [1:0] s);
        case (s)
            2'h0: return `CRSI_PAIR_X;
            2'h1: return `CRSI_PAIR_Y;
            default: return `CRSI_PAIR_Z;
        endcase
    endfunction : sel_pair

    // ==========================================================
    // Pointer addressing
    assign ptr_pair = sel_pair(ptr_sel);
    always_comb begin
        ptr_eff = ptr_base;
        ptr_new = ptr_base;
        case (ptr_mode)
            crsi_pkg::pm_disp: ptr_eff = ptr_base + 16'(ptr_disp);
            crsi_pkg::pm_postinc: ptr_new = ptr_base + `CRSI_SP_STEP1;
            crsi_pkg::pm_predec: begin
                ptr_eff = ptr_base - `CRSI_SP_STEP1;
                ptr_new = ptr_eff;
            end
            default: ptr_eff = ptr_base;
        endcase
    end

    // Write port arbitration: pointer update, data space, ALU result
    assign ptr_upd = ptr_go && (ptr_mode == crsi_pkg::pm_postinc || ptr_mode == crsi_pkg::pm_predec);
    assign ds_reg_wr = ds_wr && (ds_addr < `CRSI_RF_TOP);
    assign rf_we = ptr_upd || ds_reg_wr || res_we;
    assign rf_wide = ptr_upd || (!ds_reg_wr && res_wide);
    assign rf_idx = ptr_upd ? {ptr_pair, 1'h0} : (ds_reg_wr ? ds_addr[4:0] : res_idx);
    assign rf_data = ptr_upd ? ptr_new : (ds_reg_wr ? {8'h00, ds_wdata} : res_data);

    crsi_regfile u_rf (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .rd_a_idx(op_a_idx),
        .rd_b_idx(op_b_idx),
        .rd_c_idx(ds_addr[4:0]),
        .rd_w_idx(op_w_idx),
        .rd_p_idx(ptr_pair),
        .rd_a(rf_a),
        .rd_b(rf_b),
        .rd_c(rf_c),
        .rd_w(rf_w),
        .rd_p(ptr_base),
        .we(rf_we),
        .we_wide(rf_wide),
        .wr_idx(rf_idx),
        .wr_data(rf_data)
    );

    crsi_stack_ptr #(
        .SP_W(SP_W)
    ) u_sp (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .dec1(sp_dec1),
        .dec2(sp_dec2),
        .inc1(sp_inc1),
        .inc2(sp_inc2),
        .wr_lo(sp_wr_lo && st.st == crsi_pkg::st_idle),
        .wr_hi(sp_wr_hi && st.st == crsi_pkg::st_idle),
        .wdata(sp_wdata),
        .sp(sp16)
    );

    // ==========================================================
    // Interrupt requests
    // Level sources bypass the flags, so a vanished condition never fires
    assign req = ((st.flags & ~LEVEL_MASK) | (irq_level & LEVEL_MASK)) & irq_en;
    // Only at an instruction boundary or while sleeping, so a multi-cycle one finishes first
    assign can_take = (st.st == crsi_pkg::st_idle) && st.gie && !global_irq_off
                      && (instr_done || sleeping) && (req != '0);

    // Next state
    always_comb begin
        next_st = st;
        next_st.take = 1'h0;
        next_st.stk_we = 1'h0;
        next_st.stk_rd = 1'h0;
        next_st.pc_load = 1'h0;
        hw_clr = '0;
        sp_dec1 = 1'h0;
        sp_dec2 = 1'h0;
        sp_inc1 = 1'h0;
        sp_inc2 = 1'h0;
        // Registered operand and data-space reads
        next_st.op_a = rf_a;
        next_st.op_b = rf_b;
        next_st.op_w = rf_w;
        next_st.ds_hit = ds_rd && (ds_addr < `CRSI_RF_TOP);
        next_st.ds_rdata = rf_c;
        if (ptr_go) next_st.ptr_addr = ptr_eff;
        // Arithmetic flags only; never stacked on entry or return
        next_st.sflags = status_wr ? status_wdata[6:0] : alu_flags;
        case (st.st)
            crsi_pkg::st_idle: begin
                sp_dec1 = push1;
                sp_dec2 = sub_call;
                sp_inc1 = pop1;
                sp_inc2 = sub_exit;
                if (status_wr) next_st.gie = status_wdata[`CRSI_GIE_BIT];
                if (global_irq_on) next_st.gie = 1'h1;
                if (global_irq_off) next_st.gie = 1'h0;
                if (return_from_irq) begin
                    next_st.st = crsi_pkg::st_return;
                    next_st.cnt = '0;
                end else if (can_take) begin
                    next_st.take = 1'h1;
                    next_st.vec = pick_vec(req);
                    next_st.gie = 1'h0;
                    for (int i = 0; i < N_IRQ; i++) begin
                        hw_clr[i] = (pick_vec(req) == VW'(i + 1));
                    end
                    next_st.pc_save = 16'(pc_now);
                    next_st.st = sleeping ? crsi_pkg::st_wake : crsi_pkg::st_entry;
                    next_st.cnt = '0;
                end
            end
            crsi_pkg::st_wake: begin
                next_st.cnt = st.cnt + `CRSI_CNT_STEP;
                if (st.cnt == `CRSI_SEQ_LAST) begin
                    next_st.st = crsi_pkg::st_entry;
                    next_st.cnt = '0;
                end
            end
            crsi_pkg::st_entry: begin
                // Low PC byte at the top, high byte below it
                next_st.cnt = st.cnt + `CRSI_CNT_STEP;
                if (st.cnt == 3'h0) begin
                    next_st.stk_we = 1'h1;
                    next_st.stk_addr = sp16;
                    next_st.stk_wdata = st.pc_save[7:0];
                end else if (st.cnt == 3'h1) begin
                    next_st.stk_we = 1'h1;
                    next_st.stk_addr = sp16 - `CRSI_SP_STEP1;
                    next_st.stk_wdata = st.pc_save[15:8];
                    sp_dec2 = 1'h1;
                end else if (st.cnt == `CRSI_SEQ_LAST) begin
                    next_st.st = crsi_pkg::st_idle;
                end
            end
            crsi_pkg::st_return: begin
                // Read data arrives the cycle after each read strobe
                next_st.cnt = st.cnt + `CRSI_CNT_STEP;
                if (st.cnt == 3'h0) begin
                    next_st.stk_rd = 1'h1;
                    next_st.stk_addr = sp16 + `CRSI_SP_STEP1;
                end else if (st.cnt == 3'h1) begin
                    next_st.stk_rd = 1'h1;
                    next_st.stk_addr = sp16 + `CRSI_SP_STEP2; // Low byte; pointer moves only at this edge
                    sp_inc2 = 1'h1;
                end else if (st.cnt == 3'h2) begin
                    next_st.pc_hi = stk_rdata;
                end else begin
                    next_st.pc_restore = PC_W'({st.pc_hi, stk_rdata});
                    next_st.pc_load = 1'h1;
                    next_st.gie = 1'h1;
                    next_st.st = crsi_pkg::st_idle;
                end
            end
            default: next_st.st = crsi_pkg::st_idle;
        endcase
        // Pending flags: a new event beats a clear in the same cycle
        for (int i = 0; i < N_IRQ; i++) begin
            if (irq_event[i] && !LEVEL_MASK[i]) begin
                next_st.flags[i] = 1'h1;
            end else if (flag_clr[i] || hw_clr[i]) begin
                next_st.flags[i] = 1'h0;
            end
        end
        next_st.busy = (next_st.st != crsi_pkg::st_idle);
    end

    // Single undivided clock for the whole core
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign op_a = st.op_a;
    assign op_b = st.op_b;
    assign op_w = st.op_w;
    assign ds_reg_hit = st.ds_hit;
    assign ds_rdata = st.ds_rdata;
    assign ptr_addr = st.ptr_addr;
    assign stack_ptr_low = sp16[7:0];
    assign stack_ptr_high = sp16[15:8];
    assign status_flags_reg = {st.gie, st.sflags};
    assign irq_flags = st.flags;
    assign irq_take = st.take;
    assign irq_vector = st.vec;
    assign core_busy = st.busy;
    assign stk_we = st.stk_we;
    assign stk_rd = st.stk_rd;
    assign stk_addr = st.stk_addr;
    assign stk_wdata = st.stk_wdata;
    assign pc_load = st.pc_load;
    assign pc_restore = st.pc_restore;

    // ==========================================================
    // Checks
    default clocking crsi_cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_entry;
        (st.st == crsi_pkg::st_entry) [*4];
    endsequence
    sequence s_wake;
        (st.st == crsi_pkg::st_wake) [*4];
    endsequence
    sequence s_rtn;
        (st.st == crsi_pkg::st_return) [*4];
    endsequence

    AST_ENTRY_LEN: assert property ((st.take && st.st == crsi_pkg::st_entry) |-> s_entry ##1 !st.busy)
        else $error("entry not four cycles");
    AST_WAKE_LEN: assert property ((st.take && st.st == crsi_pkg::st_wake) |-> s_wake ##1 s_entry)
        else $error("sleep wake not four extra cycles");
    AST_ENTRY_SP: assert property ((st.take && st.st == crsi_pkg::st_entry)
        |-> ##2 (sp16 == $past(sp16, 2) - `CRSI_SP_STEP2))
        else $error("entry did not drop stack pointer by two");
    AST_RTN_SEQ: assert property ($rose(st.st == crsi_pkg::st_return) |-> s_rtn ##1 (st.gie && st.pc_load))
        else $error("return not four cycles or enable not set");
    AST_RTN_SP: assert property ($rose(st.st == crsi_pkg::st_return)
        |-> ##2 (sp16 == $past(sp16, 2) + `CRSI_SP_STEP2))
        else $error("return did not raise stack pointer by two");
    AST_TAKE_GIE: assert property (st.take |-> $past(st.gie) && !$past(global_irq_off) && !st.gie)
        else $error("interrupt taken without enable or enable left set");
    AST_SEI_DELAY: assert property ((global_irq_on && !st.gie && st.st == crsi_pkg::st_idle) |=> !st.take)
        else $error("interrupt taken right after enable");
    AST_PRIO: assert property (st.take |-> st.vec == pick_vec($past(req)))
        else $error("interrupt not served in priority order");
    AST_FLAG_HWCLR: assert property (st.take |-> (st.flags & ~$past(irq_event)
        & (N_IRQ'(1) << (st.vec - VW'(1)))) == '0)
        else $error("served flag not cleared");
    AST_FLAG_HOLD: assert property (!st.gie |=> ($past(st.flags & ~flag_clr) & ~st.flags) == '0)
        else $error("pending flag lost while disabled");

endmodule : crsi_core_ctrl
`default_nettype wire

// File: verification/crsi_stack_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// Stack memory behind the core
module crsi_stack_mem (
    input wire logic ref_clk,
    input wire logic stk_we,
    input wire logic stk_rd,
    input wire logic [15:0] stk_addr,
    input wire logic [7:0] stk_wdata,
    output logic [7:0] stk_rdata
);
    logic [7:0] mem [256];
    // Data one cycle after a read; inverted each cycle otherwise, so a stale byte reads back true only every second cycle
    always_ff @(posedge ref_clk) begin
        if (stk_we) mem[stk_addr[7:0]] <= stk_wdata;
        if (stk_rd) stk_rdata <= mem[stk_addr[7:0]];
        else stk_rdata <= ~stk_rdata;
    end
endmodule : crsi_stack_mem
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ====
// Core control bench
module tb_top;
    logic ref_clk = 0, arst_n = 0, res_we = 0, res_wide = 0, ds_rd = 0, ds_wr = 0, ptr_go = 0;
    logic push1 = 0, pop1 = 0, sub_call = 0, sub_exit = 0, sp_wr_lo = 0, sp_wr_hi = 0, status_wr = 0;
    logic instr_done = 0, global_irq_on = 0, global_irq_off = 0, return_from_irq = 0, sleeping = 0;
    logic ds_reg_hit, irq_take, core_busy, stk_we, stk_rd, pc_load;
    logic [4:0] op_a_idx = 0, op_b_idx = 0, res_idx = 0;
    logic [3:0] op_w_idx = 0, irq_vector;
    logic [7:0] op_a, op_b, ds_rdata, stack_ptr_low, stack_ptr_high, status_flags_reg, stk_wdata, stk_rdata;
    logic [7:0] ds_wdata = 0, sp_wdata = 0, status_wdata = 0;
    logic [15:0] op_w, ptr_addr, stk_addr, res_data = 0, ds_addr = 0;
    logic [1:0] ptr_sel = 0;
    crsi_pkg::crsi_ptr_mode_e ptr_mode = crsi_pkg::pm_plain;
    logic [5:0] ptr_disp = 0;
    logic [6:0] alu_flags = 0;
    logic [8:0] pc_now = 0, irq_event = 0, irq_level = 0, irq_en = 0, flag_clr = 0, irq_flags, pc_restore;
    int fails = 0, comparisons = 0;

    // Top source is level type so the unlatched request path is exercised
    crsi_core_ctrl #(.LEVEL_MASK(9'h100)) dut (.*);
    crsi_stack_mem mem_model (.*);

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    // Compare and count
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task stop_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // Bounded wait: 0 take, 1 return done, 2 idle
    task wfor(input int s);
        for (int i = 0; i < 30; i++) begin
            @(negedge ref_clk);
            if (s == 0 ? irq_take === 1'b1 : s == 1 ? pc_load === 1'b1 : core_busy === 1'b0) return;
        end
        fails++;
        stop_test();
    endtask : wfor

    // Wide ALU write, then data-space write (same cycle would drop the ALU one), read, pre-decrement, displacement and post-increment modes
    task t_regs;
        @(posedge ref_clk);
        {res_we, res_wide, res_idx, res_data} <= {2'h3, 5'h1a, 16'h0065};
        @(posedge ref_clk);
        res_we <= 0;
        {ds_wr, ds_addr, ds_wdata} <= {1'h1, 16'h0001, 8'h3c};
        @(posedge ref_clk);
        {ds_wr, ds_rd, ds_addr} <= {2'h1, 16'h001a};
        {op_w_idx, op_b_idx, op_a_idx} <= {4'hd, 5'h01, 5'h1a};
        @(posedge ref_clk);
        ds_rd <= 0;
        ptr_mode <= crsi_pkg::pm_predec;
        {ptr_go, ptr_sel} <= 3'h4;
        @(negedge ref_clk);
        chk(op_w, 16'h0065);
        chk(16'(op_a), 16'h0065);
        chk(16'(op_b), 16'h003c);
        chk(16'(ds_rdata), 16'h0065);
        chk(16'(ds_reg_hit), 16'h0001);
        @(posedge ref_clk);
        ptr_mode <= crsi_pkg::pm_disp;
        ptr_disp <= 6'h05;
        @(negedge ref_clk);
        chk(ptr_addr, 16'h0064);
        @(posedge ref_clk);
        ptr_mode <= crsi_pkg::pm_postinc;
        @(negedge ref_clk);
        chk(ptr_addr, 16'h0069);
        chk(op_w, 16'h0064);
        @(posedge ref_clk);
        ptr_go <= 0;
        @(negedge ref_clk);
        chk(ptr_addr, 16'h0064);
        @(negedge ref_clk);
        chk(op_w, 16'h0065);
        $display("regs test done");
    endtask : t_regs

    // One stack step, then check the low byte
    task step(input logic [3:0] v, input logic [7:0] e);
        @(posedge ref_clk);
        {push1, sub_call, pop1, sub_exit} <= v;
        @(posedge ref_clk);
        {push1, sub_call, pop1, sub_exit} <= 4'h0;
        @(negedge ref_clk);
        chk(16'(stack_ptr_low), 16'(e));
    endtask : step

    // Two pending sources, entry, return, then disable with a boundary in the same cycle
    task t_irq;
        @(posedge ref_clk);
        {global_irq_on, alu_flags} <= {1'h1, 7'h55};
        @(posedge ref_clk);
        {global_irq_on, irq_en, irq_event} <= {1'h0, 9'h003, 9'h003};
        @(posedge ref_clk);
        {irq_event, instr_done, pc_now} <= {9'h000, 1'h1, 9'h1a5};
        @(posedge ref_clk);
        instr_done <= 0;
        wfor(0);
        chk(16'(irq_vector), 16'h0001);
        chk(16'(status_flags_reg), 16'h0055);
        chk(16'(irq_flags), 16'h0002);
        wfor(2);
        chk(16'(stack_ptr_low), 16'h009d);
        @(posedge ref_clk);
        return_from_irq <= 1;
        @(posedge ref_clk);
        return_from_irq <= 0;
        wfor(1);
        chk(16'(pc_restore), 16'h01a5);
        chk(16'(status_flags_reg), 16'h00d5);
        chk(16'(stack_ptr_low), 16'h009f);
        @(posedge ref_clk);
        {instr_done, global_irq_off} <= 2'h3;
        @(posedge ref_clk);
        {instr_done, global_irq_off, flag_clr} <= {2'h0, 9'h002};
        @(negedge ref_clk);
        chk(16'(irq_take), 16'h0000);
        chk(16'(status_flags_reg), 16'h0055);
        @(posedge ref_clk);
        flag_clr <= 0;
        @(negedge ref_clk);
        chk(16'(irq_flags), 16'h0000);
        $display("irq test done");
    endtask : t_irq

    // Take from sleep adds four wake cycles; a level source fires only while present
    task t_wake;
        @(posedge ref_clk);
        {global_irq_on, irq_event} <= {1'h1, 9'h001};
        @(posedge ref_clk);
        {global_irq_on, irq_event, sleeping} <= {1'h0, 9'h000, 1'h1};
        wfor(0);
        chk(16'(irq_vector), 16'h0001);
        @(posedge ref_clk);
        sleeping <= 0;
        repeat (7) @(negedge ref_clk);
        chk(16'(core_busy), 16'h0001);
        @(negedge ref_clk);
        chk(16'(core_busy), 16'h0000);
        chk(16'(stack_ptr_low), 16'h009d);
        @(posedge ref_clk);
        irq_level <= 9'h100;
        @(posedge ref_clk);
        {irq_level, irq_en, global_irq_on, instr_done} <= {9'h000, 9'h103, 2'h3};
        @(posedge ref_clk);
        global_irq_on <= 0;
        @(posedge ref_clk);
        irq_level <= 9'h100;
        @(negedge ref_clk);
        chk(16'(irq_take), 16'h0000);
        @(negedge ref_clk);
        chk(16'(irq_take), 16'h0001);
        chk(16'(irq_vector), 16'h0009);
        chk(16'(irq_flags), 16'h0000);
        @(posedge ref_clk);
        {irq_level, instr_done} <= 10'h000;
        wfor(2);
        $display("wake test done");
    endtask : t_wake

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1;
        @(negedge ref_clk);
        chk(16'(stack_ptr_low), 16'h009f);
        chk(16'(stack_ptr_high), 16'h0000);
        t_regs();
        step(4'h8, 8'h9e);
        step(4'h4, 8'h9c);
        step(4'h2, 8'h9d);
        step(4'h1, 8'h9f);
        $display("stack test done");
        t_irq();
        t_wake();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
